/* File: src/relay_preset_pkg.sv */
// constants and encodings for relay condition and preset frequency selection
// Behaviour
// - select 0: on when ready, off on fault
// - select 1 at frequency, 2 motor running
// - select 3 reverse commanded, 4 motor overload
// - select 5 ramp regulator stretching ramps
// - select 6 output frequency above threshold
// - select 7 current above threshold percent
// - select 8 bus voltage above threshold
// - select 9 restart attempts limit exceeded
// - select 10 analog voltage above threshold
// - select 20 relay follows threshold bit zero
// - threshold 32 bits, used by 6,7,8,10,20
// - second ramp set uses second accel time
// - second ramp set uses second decel time
// - reference source 1 uses keypad frequency
// - up/down keys adjust keypad frequency immediately
// - enter alone stores keypad frequency
// - escape before enter restores original frequency
// - four presets default 0, 5, 10, 20 Hz
// - inputs one/two form preset index, one low
// - index 0,1 first ramp pair, 2,3 second
// - second-ramp input overrides index ramp pair
// - active preset overrides; preset 0 needs source 4
// - preset-select input has priority while active
// - second-ramp input applies second times
package relay_preset_pkg;
    localparam int         THR_W        = 32;
    localparam int         FREQ_W       = 12;
    localparam int         TIME_W       = 13;
    localparam int         SEL_W        = 5;
    localparam int         FUNC_W       = 5;
    localparam int         SRC_W        = 3;
    // frequencies in 0.1 Hz, times in 0.1 s
    localparam logic [FREQ_W-1:0] FREQ_MAX       = 12'h960;
    localparam logic [FREQ_W-1:0] KEYPAD_DEFAULT = 12'h258;
    localparam logic [FREQ_W-1:0] PRESET0_DEFAULT = 12'h000;
    localparam logic [FREQ_W-1:0] PRESET1_DEFAULT = 12'h032;
    localparam logic [FREQ_W-1:0] PRESET2_DEFAULT = 12'h064;
    localparam logic [FREQ_W-1:0] PRESET3_DEFAULT = 12'h0c8;
    localparam logic [FREQ_W-1:0] KEY_STEP       = 12'h001;
    localparam logic [TIME_W-1:0] ACCEL2_DEFAULT = 13'h00c8;
    localparam logic [TIME_W-1:0] TIME_MAX       = 13'h1770;
    // relay condition codes
    localparam logic [SEL_W-1:0] RS_READY   = 5'h00;
    localparam logic [SEL_W-1:0] RS_AT_FREQ = 5'h01;
    localparam logic [SEL_W-1:0] RS_RUNNING = 5'h02;
    localparam logic [SEL_W-1:0] RS_REVERSE = 5'h03;
    localparam logic [SEL_W-1:0] RS_OVERLD  = 5'h04;
    localparam logic [SEL_W-1:0] RS_RAMPREG = 5'h05;
    localparam logic [SEL_W-1:0] RS_ABV_FRQ = 5'h06;
    localparam logic [SEL_W-1:0] RS_ABV_CUR = 5'h07;
    localparam logic [SEL_W-1:0] RS_ABV_DCV = 5'h08;
    localparam logic [SEL_W-1:0] RS_RETRIES = 5'h09;
    localparam logic [SEL_W-1:0] RS_ABV_ANV = 5'h0a;
    localparam logic [SEL_W-1:0] RS_NETWORK = 5'h14;
    // input functions and reference sources
    localparam logic [FUNC_W-1:0] FN_RAMP2  = 5'h01;
    localparam logic [FUNC_W-1:0] FN_PRESET = 5'h04;
    localparam logic [SRC_W-1:0]  SRC_KEYPAD = 3'h1;
    localparam logic [SRC_W-1:0]  SRC_PRESET = 3'h4;
    typedef enum logic [1:0] {KP_IDLE, KP_EDIT} keypad_e;
endpackage : relay_preset_pkg

/* File: src/relay_cond_and_preset_select.sv */
// relay condition selection and preset frequency / ramp pair selection
`timescale 1ns/1ps
module relay_cond_and_preset_select
    import relay_preset_pkg::*;
(
    input  wire logic              mclk,                   // 40 MHz clock
    input  wire logic              reset_n,                // sync reset, active low
    input  wire logic [SEL_W-1:0]  relay_condition_select, // relay condition code
    input  wire logic [THR_W-1:0]  relay_threshold,        // relay trip point
    input  wire logic              drive_ready,            // powered and ready
    input  wire logic              fault_active,           // any fault active
    input  wire logic              at_frequency,           // at commanded frequency
    input  wire logic              motor_running,          // motor powered
    input  wire logic              reverse_cmd,            // reverse commanded
    input  wire logic              motor_overload,         // overload present
    input  wire logic              ramp_reg_active,        // ramp stretching
    input  wire logic [THR_W-1:0]  output_freq,            // 0.1 Hz units
    input  wire logic [THR_W-1:0]  output_current_pct,     // percent of rated
    input  wire logic [THR_W-1:0]  dc_bus_volts,           // volts
    input  wire logic [THR_W-1:0]  analog_in_pct,          // percent
    input  wire logic [3:0]        restart_attempts,       // attempts done
    input  wire logic [3:0]        restart_attempt_limit,  // max attempts
    input  wire logic              din_one,                // terminal input 1 pin
    input  wire logic              din_two,                // terminal input 2 pin
    input  wire logic [FUNC_W-1:0] input_one_function,     // input 1 function
    input  wire logic [FUNC_W-1:0] input_two_function,     // input 2 function
    input  wire logic [SRC_W-1:0]  speed_reference_source, // reference source
    input  wire logic [FREQ_W-1:0] other_speed_cmd,        // non-preset reference
    input  wire logic [TIME_W-1:0] first_accel_time,       // ramp pair 1 accel
    input  wire logic [TIME_W-1:0] first_decel_time,       // ramp pair 1 decel
    input  wire logic              preset_wr,              // preset write strobe
    input  wire logic [1:0]        preset_wr_idx,          // preset to write
    input  wire logic [FREQ_W-1:0] preset_wr_data,         // preset value
    input  wire logic              ramp2_wr,               // second ramp write strobe
    input  wire logic [TIME_W-1:0] ramp2_accel_data,       // new second accel
    input  wire logic [TIME_W-1:0] ramp2_decel_data,       // new second decel
    input  wire logic              program_mode,           // keypad program mode
    input  wire logic              key_up,                 // up key pulse
    input  wire logic              key_down,               // down key pulse
    input  wire logic              key_enter,              // enter key pulse
    input  wire logic              key_escape,             // escape key pulse
    output logic                   relay_out,              // relay energised
    output logic [FREQ_W-1:0]      freq_command,           // selected frequency
    output logic [TIME_W-1:0]      accel_time,             // selected accel time
    output logic [TIME_W-1:0]      decel_time,             // selected decel time
    output logic                   ramp2_in_use,           // second pair selected
    output logic [FREQ_W-1:0]      keypad_frequency_setting, // live keypad value
    output logic                   nv_store                // store keypad value pulse
);
    // --------------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------------
    logic [1:0] din_meta_ff;
    logic [1:0] din_sync_ff;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            din_meta_ff <= 2'h0;
            din_sync_ff <= 2'h0;
        end else begin
            din_meta_ff <= {din_two, din_one};
            din_sync_ff <= din_meta_ff;
        end
    end

    // --------------------------------------------------------------------
    // relay condition
    // --------------------------------------------------------------------
    wire abv_freq = output_freq > relay_threshold;
    wire abv_cur  = output_current_pct > relay_threshold;
    wire abv_dcv  = dc_bus_volts > relay_threshold;
    wire abv_anv  = analog_in_pct > relay_threshold;
    wire retries_exceeded = restart_attempts > restart_attempt_limit;
    logic relay_cond;
    always_comb begin
        unique case (relay_condition_select)
            RS_READY:   relay_cond = drive_ready && !fault_active;
            RS_AT_FREQ: relay_cond = at_frequency;
            RS_RUNNING: relay_cond = motor_running;
            RS_REVERSE: relay_cond = reverse_cmd;
            RS_OVERLD:  relay_cond = motor_overload;
            RS_RAMPREG: relay_cond = ramp_reg_active;
            RS_ABV_FRQ: relay_cond = abv_freq;
            RS_ABV_CUR: relay_cond = abv_cur;
            RS_ABV_DCV: relay_cond = abv_dcv;
            RS_RETRIES: relay_cond = retries_exceeded;
            RS_ABV_ANV: relay_cond = abv_anv;
            RS_NETWORK: relay_cond = relay_threshold[0];
            default:    relay_cond = 1'b0;
        endcase
    end

    // --------------------------------------------------------------------
    // preset and second ramp storage
    // --------------------------------------------------------------------
    logic [FREQ_W-1:0] preset_ff [4];
    logic [TIME_W-1:0] accel2_ff;
    logic [TIME_W-1:0] decel2_ff;
    localparam logic [FREQ_W-1:0] PRESET_DEF [4] =
        '{PRESET0_DEFAULT, PRESET1_DEFAULT, PRESET2_DEFAULT, PRESET3_DEFAULT};
    // out-of-range writes are clamped rather than refused
    wire [FREQ_W-1:0] preset_clamped = (preset_wr_data > FREQ_MAX) ? FREQ_MAX : preset_wr_data;
    wire [TIME_W-1:0] accel2_clamped = (ramp2_accel_data > TIME_MAX) ? TIME_MAX : ramp2_accel_data;
    wire [TIME_W-1:0] decel2_clamped = (ramp2_decel_data > TIME_MAX) ? TIME_MAX : ramp2_decel_data;
    generate
        for (genvar i = 0; i < 4; i++) begin : g_preset
            always_ff @(posedge mclk) begin
                if (!reset_n) begin
                    preset_ff[i] <= PRESET_DEF[i];
                end else if (preset_wr && preset_wr_idx == 2'(i)) begin
                    preset_ff[i] <= preset_clamped;
                end
            end
        end
    endgenerate
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            accel2_ff <= ACCEL2_DEFAULT;
            decel2_ff <= ACCEL2_DEFAULT;
        end else if (ramp2_wr) begin
            accel2_ff <= accel2_clamped;
            decel2_ff <= decel2_clamped;
        end
    end

    // --------------------------------------------------------------------
    // keypad frequency edit
    // --------------------------------------------------------------------
    keypad_e           kp_state_ff;
    logic [FREQ_W-1:0] kp_live_ff;
    logic [FREQ_W-1:0] kp_saved_ff;
    logic              nv_store_ff;
    wire kp_up_ok   = program_mode && key_up && kp_live_ff < FREQ_MAX;
    wire kp_down_ok = program_mode && key_down && kp_live_ff != '0;
    wire kp_adjust  = kp_up_ok || kp_down_ok;
    wire [FREQ_W-1:0] kp_stepped = kp_up_ok ? kp_live_ff + KEY_STEP : kp_live_ff - KEY_STEP;
    keypad_e           nxt_kp_state;
    logic [FREQ_W-1:0] nxt_kp_live;
    logic [FREQ_W-1:0] nxt_kp_saved;
    logic              nxt_nv_store;
    always_comb begin
        nxt_kp_state = kp_state_ff;
        nxt_kp_live  = kp_live_ff;
        nxt_kp_saved = kp_saved_ff;
        nxt_nv_store = 1'b0;
        unique case (kp_state_ff)
            KP_IDLE: begin
                if (kp_adjust) begin
                    nxt_kp_live  = kp_stepped;
                    nxt_kp_saved = kp_live_ff;
                    nxt_kp_state = KP_EDIT;
                end else if (key_enter) begin
                    nxt_nv_store = 1'b1;
                end
            end
            KP_EDIT: begin
                if (key_enter) begin
                    nxt_nv_store = 1'b1;
                    nxt_kp_saved = kp_live_ff;
                    nxt_kp_state = KP_IDLE;
                end else if (key_escape) begin
                    // the ramp generator glides back on the normal curve
                    nxt_kp_live  = kp_saved_ff;
                    nxt_kp_state = KP_IDLE;
                end else if (kp_adjust) begin
                    nxt_kp_live = kp_stepped;
                end
            end
        endcase
    end
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            kp_state_ff <= KP_IDLE;
            kp_live_ff  <= KEYPAD_DEFAULT;
            kp_saved_ff <= KEYPAD_DEFAULT;
            nv_store_ff <= 1'b0;
        end else begin
            kp_state_ff <= nxt_kp_state;
            kp_live_ff  <= nxt_kp_live;
            kp_saved_ff <= nxt_kp_saved;
            nv_store_ff <= nxt_nv_store;
        end
    end

    // --------------------------------------------------------------------
    // frequency source and ramp pair selection
    // --------------------------------------------------------------------
    wire one_preset = input_one_function == FN_PRESET;
    wire two_preset = input_two_function == FN_PRESET;
    wire [1:0] preset_idx = {two_preset & din_sync_ff[1], one_preset & din_sync_ff[0]};
    wire preset_active = (one_preset & din_sync_ff[0]) | (two_preset & din_sync_ff[1]);
    wire source_preset = speed_reference_source == SRC_PRESET;
    wire use_preset = preset_active || source_preset;
    wire ramp2_input = (input_one_function == FN_RAMP2 && din_sync_ff[0]) ||
                       (input_two_function == FN_RAMP2 && din_sync_ff[1]);
    wire ramp2_sel = ramp2_input || (use_preset && preset_idx[1]);
    wire [FREQ_W-1:0] base_cmd = (speed_reference_source == SRC_KEYPAD) ? kp_live_ff
                                                                       : other_speed_cmd;
    wire [FREQ_W-1:0] nxt_freq_cmd = use_preset ? preset_ff[preset_idx] : base_cmd;
    wire [TIME_W-1:0] nxt_accel = ramp2_sel ? accel2_ff : first_accel_time;
    wire [TIME_W-1:0] nxt_decel = ramp2_sel ? decel2_ff : first_decel_time;

    logic              relay_ff;
    logic [FREQ_W-1:0] freq_cmd_ff;
    logic [TIME_W-1:0] accel_ff;
    logic [TIME_W-1:0] decel_ff;
    logic              ramp2_ff;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            relay_ff    <= 1'b0;
            freq_cmd_ff <= '0;
            accel_ff    <= '0;
            decel_ff    <= '0;
            ramp2_ff    <= 1'b0;
        end else begin
            relay_ff    <= relay_cond;
            freq_cmd_ff <= nxt_freq_cmd;
            accel_ff    <= nxt_accel;
            decel_ff    <= nxt_decel;
            ramp2_ff    <= ramp2_sel;
        end
    end
    assign relay_out                = relay_ff;
    assign freq_command             = freq_cmd_ff;
    assign accel_time               = accel_ff;
    assign decel_time               = decel_ff;
    assign ramp2_in_use             = ramp2_ff;
    assign keypad_frequency_setting = kp_live_ff;
    assign nv_store                 = nv_store_ff;

    // --------------------------------------------------------------------
    // checks
    // --------------------------------------------------------------------
    sequence s_edit_open;
        kp_state_ff == KP_EDIT;
    endsequence
    chk_relay_ready_fault: assert property (@(posedge mclk) disable iff (!reset_n)
        relay_condition_select == RS_READY && fault_active |=> !relay_out)
        else $error("relay on with fault in ready mode");
    chk_relay_network_bit: assert property (@(posedge mclk) disable iff (!reset_n)
        relay_condition_select == RS_NETWORK |=> relay_out == $past(relay_threshold[0]))
        else $error("relay not following network bit");
    chk_relay_above_freq: assert property (@(posedge mclk) disable iff (!reset_n)
        relay_condition_select == RS_ABV_FRQ |=> relay_out == $past(abv_freq))
        else $error("above-frequency relay wrong");
    chk_relay_reserved_off: assert property (@(posedge mclk) disable iff (!reset_n)
        relay_condition_select inside {[5'h0b:5'h13]} |=> !relay_out)
        else $error("reserved select drove relay");
    chk_ramp_pair_two: assert property (@(posedge mclk) disable iff (!reset_n)
        ramp2_input |=> ramp2_in_use && accel_time == $past(accel2_ff))
        else $error("second ramp input ignored");
    chk_preset_priority: assert property (@(posedge mclk) disable iff (!reset_n)
        preset_active |=> freq_command == $past(preset_ff[preset_idx]))
        else $error("active preset did not override");
    chk_escape_restore: assert property (@(posedge mclk) disable iff (!reset_n)
        s_edit_open ##0 (key_escape && !key_enter) |=> keypad_frequency_setting == $past(kp_saved_ff))
        else $error("escape did not restore keypad frequency");
    chk_enter_store: assert property (@(posedge mclk) disable iff (!reset_n)
        nv_store |-> $past(key_enter))
        else $error("store without enter");
endmodule : relay_cond_and_preset_select

/* File: verification/terminal_model.sv */
// far-side model: two terminal input pins and the relay contact they face
`timescale 1ns/1ps
module terminal_model (
    input  wire logic       mclk,      // bench clock
    input  wire logic [1:0] want,      // requested pin levels, bit 0 is input 1
    input  wire logic       relay_out, // relay coil drive
    output logic            din_one,   // terminal input 1
    output logic            din_two,   // terminal input 2
    output logic            contact    // contact state, one clock late
);
    // pins are driven straight, the design owns the synchroniser
    assign din_one = want[0];
    assign din_two = want[1];
    always_ff @(posedge mclk) contact <= relay_out;
endmodule : terminal_model

/* File: verification/testbench.sv */
// self-checking bench for relay condition and preset frequency selection
`timescale 1ns/1ps
module testbench;
    import relay_preset_pkg::*;
    logic              mclk, reset_n, drive_ready, fault_active, at_frequency, motor_running, reverse_cmd;
    logic              motor_overload, ramp_reg_active, preset_wr, ramp2_wr, program_mode, key_up, key_down;
    logic              key_enter, key_escape, din_one, din_two, relay_out, ramp2_in_use, nv_store, contact;
    logic [SEL_W-1:0]  relay_condition_select;
    logic [THR_W-1:0]  relay_threshold, output_freq, output_current_pct, dc_bus_volts, analog_in_pct;
    logic [3:0]        restart_attempts, restart_attempt_limit;
    logic [FUNC_W-1:0] input_one_function, input_two_function;
    logic [SRC_W-1:0]  speed_reference_source;
    logic [FREQ_W-1:0] other_speed_cmd, preset_wr_data, freq_command, keypad_frequency_setting;
    logic [TIME_W-1:0] first_accel_time, first_decel_time, ramp2_accel_data, ramp2_decel_data;
    logic [TIME_W-1:0] accel_time, decel_time;
    logic [1:0]        preset_wr_idx, want;
    int                num_errors, cmp_count;
    logic [SEL_W-1:0]  tsel [4] = '{RS_ABV_FRQ, RS_ABV_CUR, RS_ABV_DCV, RS_ABV_ANV};
    logic [THR_W-1:0]  tval [4] = '{32'h0000_00f0, 32'h0000_00b4, 32'h0000_032f, 32'h0000_0064};
    logic [FREQ_W-1:0] pdef [4] = '{PRESET0_DEFAULT, PRESET1_DEFAULT, PRESET2_DEFAULT, PRESET3_DEFAULT};

    relay_cond_and_preset_select relay_cond_and_preset_select_i (
        .mclk(mclk), .reset_n(reset_n), .relay_condition_select(relay_condition_select),
        .relay_threshold(relay_threshold), .drive_ready(drive_ready), .fault_active(fault_active),
        .at_frequency(at_frequency), .motor_running(motor_running), .reverse_cmd(reverse_cmd),
        .motor_overload(motor_overload), .ramp_reg_active(ramp_reg_active), .output_freq(output_freq),
        .output_current_pct(output_current_pct), .dc_bus_volts(dc_bus_volts), .analog_in_pct(analog_in_pct),
        .restart_attempts(restart_attempts), .restart_attempt_limit(restart_attempt_limit),
        .din_one(din_one), .din_two(din_two), .input_one_function(input_one_function),
        .input_two_function(input_two_function), .speed_reference_source(speed_reference_source),
        .other_speed_cmd(other_speed_cmd), .first_accel_time(first_accel_time), .first_decel_time(first_decel_time),
        .preset_wr(preset_wr), .preset_wr_idx(preset_wr_idx), .preset_wr_data(preset_wr_data),
        .ramp2_wr(ramp2_wr), .ramp2_accel_data(ramp2_accel_data), .ramp2_decel_data(ramp2_decel_data),
        .program_mode(program_mode), .key_up(key_up), .key_down(key_down), .key_enter(key_enter),
        .key_escape(key_escape), .relay_out(relay_out), .freq_command(freq_command), .accel_time(accel_time),
        .decel_time(decel_time), .ramp2_in_use(ramp2_in_use), .keypad_frequency_setting(keypad_frequency_setting),
        .nv_store(nv_store));
    terminal_model terminal_model_i (.mclk(mclk), .want(want), .relay_out(relay_out), .din_one(din_one),
        .din_two(din_two), .contact(contact));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk_bit(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_bit
    task automatic chk_val(input string what, input logic [TIME_W-1:0] exp, input logic [TIME_W-1:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val
    // pins need two extra edges, so four covers every path
    task automatic settle();
        repeat (4) @(posedge mclk);
        #1;
    endtask : settle
    task automatic flags(input logic [6:0] f);
        {ramp_reg_active, motor_overload, reverse_cmd, motor_running} = f[6:3];
        {at_frequency, fault_active, drive_ready} = f[2:0];
    endtask : flags
    task automatic meas(input int i, input logic [THR_W-1:0] hit, input logic [THR_W-1:0] rest);
        output_freq        = (i == 0) ? hit : rest;
        output_current_pct = (i == 1) ? hit : rest;
        dc_bus_volts       = (i == 2) ? hit : rest;
        analog_in_pct      = (i == 3) ? hit : rest;
    endtask : meas
    task automatic key(input int k);
        // one idle edge first, so back-to-back presses never glitch a key
        @(posedge mclk);
        #1;
        {key_escape, key_enter, key_down, key_up} = 4'h1 << k;
        @(posedge mclk);
        #1;
        {key_escape, key_enter, key_down, key_up} = 4'h0;
    endtask : key
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    // ------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        #2_000_000;
        num_errors++;
        wrap_up();
    end
    initial begin
        reset_n = 1'b0;
        {preset_wr, ramp2_wr, program_mode, want, key_escape, key_enter, key_down, key_up} = 9'h000;
        flags(7'h00);
        meas(0, 32'h0, 32'h0);
        {relay_condition_select, relay_threshold} = '0;
        {restart_attempts, restart_attempt_limit, input_one_function, input_two_function} = '0;
        speed_reference_source = 3'h0;
        other_speed_cmd = 12'h123;
        {first_accel_time, first_decel_time} = {13'h0064, 13'h0032};
        {preset_wr_idx, preset_wr_data, ramp2_accel_data, ramp2_decel_data} = '0;
        repeat (12) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        settle();
        chk_val("keypad after reset", {1'b0, KEYPAD_DEFAULT}, {1'b0, keypad_frequency_setting});
        chk_val("other reference", 13'h0123, {1'b0, freq_command});
        $display("test reset done");
        flags(7'h01);
        settle();
        chk_bit("ready relay", 1'b1, relay_out);
        chk_bit("relay contact", 1'b1, contact);
        flags(7'h03);
        settle();
        chk_bit("fault relay", 1'b0, relay_out);
        for (int m = 1; m <= 5; m++) begin
            relay_condition_select = SEL_W'(m);
            flags(7'h01 << (m + 1));
            settle();
            chk_bit("status relay on", 1'b1, relay_out);
            flags(~(7'h01 << (m + 1)));
            settle();
            chk_bit("status relay off", 1'b0, relay_out);
        end
        for (int i = 0; i < 4; i++) begin
            relay_condition_select = tsel[i];
            relay_threshold = tval[i];
            meas(i, tval[i], tval[i] + 1);
            settle();
            chk_bit("level relay equal", 1'b0, relay_out);
            meas(i, tval[i] + 1, tval[i]);
            settle();
            chk_bit("level relay above", 1'b1, relay_out);
        end
        relay_condition_select = RS_RETRIES;
        {restart_attempts, restart_attempt_limit} = 8'h99;
        settle();
        chk_bit("retries equal", 1'b0, relay_out);
        restart_attempts = 4'ha;
        settle();
        chk_bit("retries exceeded", 1'b1, relay_out);
        relay_condition_select = RS_NETWORK;
        flags(7'h7f);
        meas(0, 32'hffff_ffff, 32'hffff_ffff);
        for (int v = 1; v >= 0; v--) begin
            relay_threshold = THR_W'(v);
            settle();
            chk_bit("network relay", v[0], relay_out);
        end
        relay_threshold = 32'h0000_0001;
        for (int s = 11; s < 32; s++) begin
            relay_condition_select = SEL_W'(s);
            settle();
            if (s != 20) chk_bit("reserved relay", 1'b0, relay_out);
        end
        $display("test relay modes done");
        {input_one_function, input_two_function} = {FN_PRESET, FN_PRESET};
        speed_reference_source = SRC_KEYPAD;
        settle();
        chk_val("preset zero gated", {1'b0, KEYPAD_DEFAULT}, {1'b0, freq_command});
        speed_reference_source = SRC_PRESET;
        for (int p = 0; p < 4; p++) begin
            want = 2'(p);
            settle();
            chk_val("preset freq", {1'b0, pdef[p]}, {1'b0, freq_command});
            chk_val("preset accel", (p > 1) ? ACCEL2_DEFAULT : first_accel_time, accel_time);
            chk_val("preset decel", (p > 1) ? ACCEL2_DEFAULT : first_decel_time, decel_time);
            chk_bit("preset pair", p > 1, ramp2_in_use);
        end
        speed_reference_source = 3'h0;
        want = 2'b10;
        settle();
        chk_val("preset over other", {1'b0, PRESET2_DEFAULT}, {1'b0, freq_command});
        {preset_wr_idx, preset_wr_data, preset_wr} = {2'h3, 12'hfff, 1'b1};
        {ramp2_accel_data, ramp2_decel_data, ramp2_wr} = {13'h1fff, 13'h0123, 1'b1};
        @(posedge mclk);
        #1;
        {preset_wr, ramp2_wr} = 2'b00;
        {speed_reference_source, want} = {SRC_PRESET, 2'b11};
        settle();
        chk_val("preset clamped", {1'b0, FREQ_MAX}, {1'b0, freq_command});
        chk_val("accel two", TIME_MAX, accel_time);
        chk_val("decel two", 13'h0123, decel_time);
        // second-ramp input on pin 1 outranks the table row of index 0
        {input_one_function, want} = {FN_RAMP2, 2'b01};
        settle();
        chk_val("ramp input freq", {1'b0, PRESET0_DEFAULT}, {1'b0, freq_command});
        chk_bit("ramp input pair", 1'b1, ramp2_in_use);
        chk_val("ramp input accel", TIME_MAX, accel_time);
        chk_val("ramp input decel", 13'h0123, decel_time);
        $display("test presets done");
        {input_one_function, input_two_function, want} = '0;
        {speed_reference_source, program_mode} = {SRC_KEYPAD, 1'b1};
        key(0);
        chk_val("up at once", 13'h0259, {1'b0, keypad_frequency_setting});
        key(0);
        settle();
        chk_val("freq from keypad", 13'h025a, {1'b0, freq_command});
        chk_bit("no store yet", 1'b0, nv_store);
        key(3);
        settle();
        chk_val("escape restores", {1'b0, KEYPAD_DEFAULT}, {1'b0, keypad_frequency_setting});
        key(0);
        key(1);
        key(0);
        key(2);
        chk_bit("store pulse", 1'b1, nv_store);
        settle();
        chk_bit("store ends", 1'b0, nv_store);
        key(3);
        settle();
        chk_val("kept after enter", 13'h0259, {1'b0, keypad_frequency_setting});
        $display("test keypad done");
        wrap_up();
    end
endmodule : testbench
